// ---- design/pcs_pkg.sv ----
// Purpose: shared constants and carriers for the sequencing block
// Assumes: 8-bit data path, 13-bit program counter, one core clock
// Notes:   special file addresses mirror in every bank (low 7 bits)
`default_nettype none
package pcs_pkg;
  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int PC_W      = 13;             // program counter width
  localparam int TGT_W     = 11;             // call/jump target width
  localparam int HI_W      = 5;              // upper counter bits
  localparam int STK_DEPTH = 8;              // return stack levels
  localparam int STK_PTR_W = 3;              // stack index width
  localparam int DAT_W     = 8;              // data byte width
  localparam int FADR_W    = 9;              // file address width
  // ----------------------------------------
  // special file addresses (low 7 bits)
  // ----------------------------------------
  localparam logic [6:0] ADR_IND_PORT   = 7'h00; // indirect data port
  localparam logic [6:0] ADR_LOW_BYTE   = 7'h02; // counter low byte
  localparam logic [6:0] ADR_PTR        = 7'h04; // indirect pointer
  localparam logic [6:0] ADR_HIGH_LATCH = 7'h0a; // high latch
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int PAGE_LSB = 3;               // page bits in latch <4:3>
  localparam int PAGE_MSB = 4;
  localparam logic [PC_W-1:0]      PC_RESET    = 13'h0000;
  localparam logic [PC_W-1:0]      IRQ_VECTOR  = 13'h0004;
  localparam logic [DAT_W-1:0]     LATCH_RESET = 8'h00;
  localparam logic [DAT_W-1:0]     PTR_RESET   = 8'h00;
  localparam logic [STK_PTR_W-1:0] SP_RESET    = 3'h0;
  localparam logic [DAT_W-1:0]     SELF_READ   = 8'h00;
  // ----------------------------------------
  // sequencing commands from the decoder
  // ----------------------------------------
  typedef enum logic [2:0] {
    PCS_OP_HOLD   = 3'h0,  // keep counter
    PCS_OP_STEP   = 3'h1,  // advance by one
    PCS_OP_JUMP   = 3'h2,  // paged jump
    PCS_OP_CALL   = 3'h3,  // paged call, push
    PCS_OP_RET    = 3'h4,  // plain return
    PCS_OP_RETLIT = 3'h5,  // return_with_literal
    PCS_OP_RETINT = 3'h6,  // return_from_interrupt
    PCS_OP_IRQ    = 3'h7   // interrupt vector, push
  } pcs_op_t;
  // command carrier
  typedef struct packed {
    pcs_op_t              op;      // what to do
    logic [TGT_W-1:0]     target;  // 11-bit branch target
  } pcs_cmd_t;
  // file access request from decoder
  typedef struct packed {
    logic                 valid;   // access this cycle
    logic                 we;      // write when high
    logic [FADR_W-1:0]    addr;    // direct 9-bit address
    logic [DAT_W-1:0]     wdata;   // write data
  } pcs_freq_t;
  // request toward data memory
  typedef struct packed {
    logic                 valid;
    logic                 we;
    logic [FADR_W-1:0]    addr;
    logic [DAT_W-1:0]     wdata;
  } pcs_mreq_t;
  // read answer from this block
  typedef struct packed {
    logic                 valid;
    logic [DAT_W-1:0]     data;
  } pcs_rans_t;
  // file address classes
  typedef enum logic [2:0] {
    PCS_CLS_MEM  = 3'h0,
    PCS_CLS_SELF = 3'h1,
    PCS_CLS_LOW  = 3'h2,
    PCS_CLS_PTR  = 3'h3,
    PCS_CLS_HIGH = 3'h4
  } pcs_cls_t;
endpackage : pcs_pkg
`default_nettype wire

// ---- design/pcs_ret_stack.sv ----
// Purpose: circular return stack of program counter values
// Assumes: push and pop never asserted in the same cycle
// Notes:   no overflow or underflow detection, index wraps
`default_nettype none
module pcs_ret_stack
  import pcs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [PC_W-1:0]  push_data,
  output logic      [PC_W-1:0]  pop_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [PC_W-1:0]      entry_reg [STK_DEPTH]; // stack entries
  logic [STK_PTR_W-1:0] sp_reg;               // next free slot
  logic [STK_PTR_W-1:0] top_idx;              // last pushed slot

  // top of stack is one below the free slot, wrapping
  assign top_idx  = sp_reg - STK_PTR_W'(1);
  assign pop_data = entry_reg[top_idx];

  // write slot on push; ninth push lands on first slot again
  always_ff @(posedge core_clk) begin
    if (push) begin
      entry_reg[sp_reg] <= push_data;
    end
  end

  // index moves; hidden from software entirely
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sp_reg <= SP_RESET;
    end else if (push) begin
      sp_reg <= sp_reg + STK_PTR_W'(1);
    end else if (pop) begin
      sp_reg <= top_idx;
    end
  end
endmodule // pcs_ret_stack
`default_nettype wire

// ---- design/pcs_seq.sv ----
// Purpose: program counter sequencing, return stack, paging and
//          indirect data addressing for the core
// Assumes: decoder sends one command and at most one file access
//          per cycle; status bank bit comes from the status reg
// Notes:   all answers appear one cycle after the request
`default_nettype none
module pcs_seq
  import pcs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire pcs_cmd_t         cmd,
  input  wire pcs_freq_t        freq,
  input  wire logic             indirect_bank_bit,
  output pcs_mreq_t             mreq,
  output pcs_rans_t             rans,
  output logic      [PC_W-1:0]  fetch_addr
);
  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // classify a 9-bit file address (specials mirror in all banks)
  function automatic pcs_cls_t classify(input logic [FADR_W-1:0] a);
    pcs_cls_t c;
    c = PCS_CLS_MEM;
    if (a[6:0] == ADR_IND_PORT) begin
      c = PCS_CLS_SELF;
    end else if (a[6:0] == ADR_LOW_BYTE) begin
      c = PCS_CLS_LOW;
    end else if (a[6:0] == ADR_PTR) begin
      c = PCS_CLS_PTR;
    end else if (a[6:0] == ADR_HIGH_LATCH) begin
      c = PCS_CLS_HIGH;
    end
    return c;
  endfunction

  // paged branch target from latch and 11-bit field
  function automatic logic [PC_W-1:0] paged(
    input logic [DAT_W-1:0] latch,
    input logic [TGT_W-1:0] tgt
  );
    return {latch[PAGE_MSB:PAGE_LSB], tgt};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [PC_W-1:0]   program_counter;     // 8K-word fetch address
  logic [DAT_W-1:0]  counter_high_latch;  // staging for upper bits
  logic [DAT_W-1:0]  indirect_pointer;    // pointer register
  pcs_mreq_t         mreq_reg;            // memory request out
  pcs_rans_t         rans_reg;            // read answer out

  // ----------------------------------------
  // file access resolution
  // ----------------------------------------
  logic              is_ind;              // access via port
  logic [FADR_W-1:0] eff_addr;            // resolved address
  pcs_cls_t          eff_cls;             // class of target
  logic              wr_low;              // writes low byte
  logic              wr_high;             // writes latch
  logic              wr_ptr;              // writes pointer

  // the port holds nothing: use bank bit and pointer instead
  always_comb begin
    is_ind   = freq.valid && (classify(freq.addr) == PCS_CLS_SELF);
    eff_addr = freq.addr;
    if (is_ind) begin
      eff_addr = {indirect_bank_bit, indirect_pointer};
    end
    eff_cls  = classify(eff_addr);
    // a self-pointing port write falls through to no target
    wr_low   = freq.valid && freq.we && (eff_cls == PCS_CLS_LOW);
    wr_high  = freq.valid && freq.we && (eff_cls == PCS_CLS_HIGH);
    wr_ptr   = freq.valid && freq.we && (eff_cls == PCS_CLS_PTR);
  end

  // ----------------------------------------
  // stack control
  // ----------------------------------------
  logic              stk_push;            // save counter
  logic              stk_pop;             // restore counter
  logic [PC_W-1:0]   stk_top;             // restored value

  // calls and interrupts save; three return kinds restore
  always_comb begin
    // a low byte write refuses the command, stack moves included
    stk_push = !wr_low && ((cmd.op == PCS_OP_CALL) || (cmd.op == PCS_OP_IRQ));
    stk_pop  = !wr_low && ((cmd.op == PCS_OP_RET) || (cmd.op == PCS_OP_RETLIT)
            || (cmd.op == PCS_OP_RETINT));
  end

  // stack lives apart from program and data space
  pcs_ret_stack u_stack (
    .core_clk  (core_clk),
    .reset     (reset),
    .push      (stk_push),
    .pop       (stk_pop),
    .push_data (program_counter),
    .pop_data  (stk_top)
  );

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  // a low byte write wins over the command in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_counter <= PC_RESET;
    end else if (wr_low) begin
      // upper bits only ever come from the latch
      program_counter <= {counter_high_latch[HI_W-1:0],
                          freq.wdata};
    end else begin
      case (cmd.op)
        PCS_OP_STEP: begin
          program_counter <= program_counter + PC_W'(1);
        end
        PCS_OP_JUMP, PCS_OP_CALL: begin
          program_counter <= paged(counter_high_latch, cmd.target);
        end
        PCS_OP_RET, PCS_OP_RETLIT, PCS_OP_RETINT: begin
          program_counter <= stk_top;
        end
        PCS_OP_IRQ: begin
          program_counter <= IRQ_VECTOR;
        end
        default: begin
          program_counter <= program_counter;
        end
      endcase
    end
  end

  // ----------------------------------------
  // high latch and pointer
  // ----------------------------------------
  // latch changes only by file write, never by push or pop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      counter_high_latch <= LATCH_RESET;
    end else if (wr_high) begin
      counter_high_latch <= freq.wdata;
    end
  end

  // pointer register for indirect access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      indirect_pointer <= PTR_RESET;
    end else if (wr_ptr) begin
      indirect_pointer <= freq.wdata;
    end
  end

  // ----------------------------------------
  // memory request
  // ----------------------------------------
  // ordinary targets go to data memory at the resolved address
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mreq_reg <= '0;
    end else begin
      mreq_reg.valid <= freq.valid && (eff_cls == PCS_CLS_MEM);
      mreq_reg.we    <= freq.we;
      mreq_reg.addr  <= eff_addr;
      mreq_reg.wdata <= freq.wdata;
    end
  end

  // ----------------------------------------
  // read answers for registers held here
  // ----------------------------------------
  // stack index has no read path at all
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rans_reg <= '0;
    end else begin
      rans_reg.valid <= 1'b0;
      rans_reg.data  <= SELF_READ;
      if (freq.valid && !freq.we) begin
        case (eff_cls)
          PCS_CLS_SELF: begin
            rans_reg.valid <= 1'b1;
            rans_reg.data  <= SELF_READ;
          end
          PCS_CLS_LOW: begin
            rans_reg.valid <= 1'b1;
            rans_reg.data  <= program_counter[DAT_W-1:0];
          end
          PCS_CLS_PTR: begin
            rans_reg.valid <= 1'b1;
            rans_reg.data  <= indirect_pointer;
          end
          PCS_CLS_HIGH: begin
            rans_reg.valid <= 1'b1;
            rans_reg.data  <= counter_high_latch;
          end
          default: begin
            // memory answers this one itself
            rans_reg.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // a self-pointing indirect write reaches neither memory nor regs
  assign mreq       = mreq_reg;
  assign rans       = rans_reg;
  assign fetch_addr = program_counter;
endmodule // pcs_seq
`default_nettype wire

// ---- tb/pcs_seq_monitor.sv ----
// Purpose: port-level assertions for the sequencing block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto every pcs_seq instance below
`default_nettype none
module pcs_seq_monitor
  import pcs_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire pcs_cmd_t        cmd,
  input  wire pcs_freq_t       freq,
  input  wire logic            indirect_bank_bit,
  input  wire pcs_mreq_t       mreq,
  input  wire pcs_rans_t       rans,
  input  wire logic [PC_W-1:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic wr_pc;  // a write that may land on the low byte
  logic wr_low; // direct low byte write
  assign wr_pc  = freq.valid && freq.we &&
                  (freq.addr[6:0] == ADR_LOW_BYTE || freq.addr[6:0] == ADR_IND_PORT);
  assign wr_low = freq.valid && freq.we && freq.addr[6:0] == ADR_LOW_BYTE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_call;
    cmd.op == PCS_OP_CALL && !wr_pc;
  endsequence
  sequence s_ret;
    cmd.op inside {PCS_OP_RET, PCS_OP_RETLIT, PCS_OP_RETINT} && !wr_pc;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_step_wraps: assert property (
    cmd.op == PCS_OP_STEP && !wr_pc |=> fetch_addr == $past(fetch_addr) + 13'h0001)
    else $error("step did not advance counter by one");
  chk_branch_target: assert property (
    cmd.op inside {PCS_OP_JUMP, PCS_OP_CALL} && !wr_pc |=> fetch_addr[10:0] == $past(cmd.target))
    else $error("branch target not loaded");
  chk_irq_vector: assert property (
    cmd.op == PCS_OP_IRQ && !wr_pc |=> fetch_addr == IRQ_VECTOR)
    else $error("interrupt vector not loaded");
  chk_call_return: assert property (
    s_call ##1 s_ret |=> fetch_addr == $past(fetch_addr, 2))
    else $error("return did not restore call address");
  chk_low_write: assert property (
    wr_low |=> fetch_addr[7:0] == $past(freq.wdata))
    else $error("low byte write not taken");
  chk_hold_keeps: assert property (
    cmd.op == PCS_OP_HOLD && !wr_pc |=> $stable(fetch_addr))
    else $error("counter moved on hold");
  chk_idle_quiet: assert property (
    !freq.valid |=> !mreq.valid && !rans.valid)
    else $error("answer without access");
  chk_reset_clear: assert property (
    $fell(reset) |-> fetch_addr == PC_RESET && !mreq.valid && !rans.valid)
    else $error("outputs not cleared by reset");
endmodule // pcs_seq_monitor
bind pcs_seq pcs_seq_monitor pcs_seq_monitor_inst (
  .core_clk(core_clk), .reset(reset), .cmd(cmd), .freq(freq),
  .indirect_bank_bit(indirect_bank_bit), .mreq(mreq), .rans(rans), .fetch_addr(fetch_addr));
`default_nettype wire

// ---- tb/pcs_mem_model.sv ----
// Purpose: data memory standing behind the block
// Assumes: requests arrive as one-cycle pulses
// Notes:   reads need no answer, the model holds no read path
`default_nettype none
module pcs_mem_model
  import pcs_pkg::*;
(
  input  wire logic      core_clk,
  input  wire pcs_mreq_t mreq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DAT_W-1:0] mem [512]; // 9-bit addressed file
  // store forwarded writes
  always_ff @(posedge core_clk) begin
    if (mreq.valid && mreq.we) begin
      mem[mreq.addr] <= mreq.wdata;
    end
  end
endmodule // pcs_mem_model
`default_nettype wire

// ---- tb/pcs_seq_tb.sv ----
// Purpose: self-checking bench for the sequencing block
// Assumes: inputs change on the falling edge, answers one cycle late
// Notes:   table rows first, then reset and stack wrap by hand
`default_nettype none
module pcs_seq_tb
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    pcs_cmd_t        c;  // command
    pcs_freq_t       f;  // file access
    logic            b;  // bank bit
    logic [PC_W-1:0] pc; // expected counter
    pcs_rans_t       r;  // expected answer
    pcs_freq_t       m;  // expected memory request
  } pcs_row_t;
  logic            core_clk;
  logic            reset;
  logic            bank;
  pcs_cmd_t        cmd;
  pcs_freq_t       freq;
  pcs_mreq_t       mreq;
  pcs_rans_t       rans;
  logic [PC_W-1:0] fetch_addr;
  int              error_cnt;
  int              n_checks;
  pcs_row_t        rows [21];
  pcs_seq pcs_seq_inst (.core_clk(core_clk), .reset(reset), .cmd(cmd), .freq(freq),
    .indirect_bank_bit(bank), .mreq(mreq), .rans(rans), .fetch_addr(fetch_addr));
  pcs_mem_model pcs_mem_model_inst (.core_clk(core_clk), .mreq(mreq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic pcs_freq_t fa(input logic w, input logic [8:0] a, input logic [7:0] d);
    fa = {1'b1, w, a, d};
  endfunction
  function automatic pcs_row_t mk(input pcs_op_t o, input logic [10:0] t, input pcs_freq_t f,
      input logic b, input logic [12:0] pc, input pcs_rans_t r, input pcs_freq_t m);
    mk = {o, t, f, b, pc, r, m};
  endfunction
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pc(input logic [PC_W-1:0] e);
    chk(19'(fetch_addr), 19'(e));
  endtask
  task automatic cmp_ans(input pcs_rans_t e);
    pcs_rans_t g;
    g = rans;
    if (!e.valid) g.data = e.data; // data idle is free
    chk(19'(g), 19'(e));
  endtask
  task automatic cmp_mem(input pcs_freq_t e);
    pcs_freq_t g;
    g = pcs_freq_t'(mreq);
    if (!e.we) g.wdata = e.wdata; // read carries no data
    if (!e.valid) g = {g.valid, e[17:0]};
    chk(19'(g), 19'(e));
  endtask
  // data memory cell after forwarded writes
  task automatic cmp_cell(input logic [FADR_W-1:0] a, input logic [DAT_W-1:0] e);
    chk(19'(pcs_mem_model_inst.mem[a]), 19'(e));
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #8000;
    error_cnt++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    cmd = '0;
    freq = '0;
    bank = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    rows[0]  = mk(PCS_OP_STEP, 11'h000, '0, 1'b0, 13'h0001, '0, '0);
    // page bits set before any branch
    rows[1]  = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h00a, 8'h18), 1'b0, 13'h0001,
                  '0, '0);
    rows[2]  = mk(PCS_OP_JUMP, 11'h7ff, '0, 1'b0, 13'h1fff, '0, '0);
    rows[3]  = mk(PCS_OP_STEP, 11'h000, '0, 1'b0, 13'h0000, '0, '0);
    rows[4]  = mk(PCS_OP_CALL, 11'h123, '0, 1'b0, 13'h1923, '0, '0);
    rows[5]  = mk(PCS_OP_IRQ, 11'h000, '0, 1'b0, 13'h0004, '0, '0);
    rows[6]  = mk(PCS_OP_RETINT, 11'h000, '0, 1'b0, 13'h1923, '0, '0);
    rows[7]  = mk(PCS_OP_RETLIT, 11'h000, '0, 1'b0, 13'h0000, '0, '0);
    rows[8]  = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h08a, 8'h00), 1'b0, 13'h0000,
                  9'h118, '0);
    rows[9]  = mk(PCS_OP_STEP, 11'h000, fa(1'b1, 9'h002, 8'h5a), 1'b0, 13'h185a,
                  '0, '0);
    rows[10] = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h002, 8'h00), 1'b0, 13'h185a,
                  9'h15a, '0);
    rows[11] = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h004, 8'h25), 1'b0, 13'h185a,
                  '0, '0);
    rows[12] = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h000, 8'h00), 1'b1, 13'h185a,
                  '0, fa(1'b0, 9'h125, 8'h00));
    rows[13] = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h000, 8'h77), 1'b1, 13'h185a,
                  '0, fa(1'b1, 9'h125, 8'h77));
    rows[14] = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h004, 8'h00), 1'b0, 13'h185a,
                  '0, '0);
    rows[15] = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h000, 8'h00), 1'b0, 13'h185a,
                  9'h100, '0);
    rows[16] = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h000, 8'h33), 1'b0, 13'h185a,
                  '0, '0);
    rows[17] = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h020, 8'h00), 1'b0, 13'h185a,
                  '0, fa(1'b0, 9'h020, 8'h00));
    // pointer through a bank mirror, read back
    rows[18] = mk(PCS_OP_HOLD, 11'h000, fa(1'b1, 9'h104, 8'h02), 1'b0, 13'h185a,
                  '0, '0);
    rows[19] = mk(PCS_OP_HOLD, 11'h000, fa(1'b0, 9'h084, 8'h00), 1'b0, 13'h185a,
                  9'h102, '0);
    // indirect write lands on the low byte, call refused
    rows[20] = mk(PCS_OP_CALL, 11'h3ff, fa(1'b1, 9'h000, 8'h11), 1'b0, 13'h1811,
                  '0, '0);
    repeat (4) @(negedge core_clk);
    cmp_pc(PC_RESET);
    reset = 1'b0;
    // table of ordinary cases
    for (int i = 0; i < 21; i++) begin
      cmd = rows[i].c;
      freq = rows[i].f;
      bank = rows[i].b;
      @(negedge core_clk);
      cmp_pc(rows[i].pc);
      cmp_ans(rows[i].r);
      cmp_mem(rows[i].m);
    end
    cmp_cell(9'h125, 8'h77);
    // second reset in mid-run, with a pending read masked by it
    cmd = '0;
    freq = fa(1'b0, 9'h002, 8'h00);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    freq = '0;
    cmp_pc(PC_RESET);
    cmp_ans('0);
    // nine calls then nine returns, stack wraps
    for (int i = 1; i <= 9; i++) begin
      cmd = pcs_cmd_t'{PCS_OP_CALL, 11'(i * 16)};
      @(negedge core_clk);
      cmp_pc(13'(i * 16));
    end
    for (int i = 8; i >= 0; i--) begin
      cmd = pcs_cmd_t'{PCS_OP_RET, 11'h000};
      @(negedge core_clk);
      cmp_pc(13'(i == 0 ? 128 : i * 16));
    end
    cmd = '0;
    give_verdict();
  end
endmodule // pcs_seq_tb
`default_nettype wire
